// >>> hw/lwc_cfg.svh
`ifndef LWC_CFG_SVH
`define LWC_CFG_SVH

// clock rate and link timing
`define LWC_CLK_MHZ 200
`define LWC_MODE_SETTLE_NS 10000
`define LWC_NORMAL_INIT_NS 5000
`define LWC_BIT_NS 50000

// fifo shape and byte frame
`define LWC_FIFO_WIDTH 8
`define LWC_FIFO_DEPTH 4
`define LWC_FRAME_BITS 10

// reset levels of the pins
`define LWC_EN_RST 1'b0
`define LWC_TXD_RST 1'b1

`endif

// >>> hw/lwc_fifo.sv
`timescale 1ns/1ps
`include "lwc_cfg.svh"

module lwc_fifo import lwc_pkg::*; #(
  parameter int WIDTH = `LWC_FIFO_WIDTH,
  parameter int DEPTH = `LWC_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic ready_reg, ready_next, empty_reg, empty_next;
  logic push, pop;

  // ready is kept as its own flop so the port comes straight from a register
  assign in_ready = ready_reg;
  assign out_valid = !empty_reg;
  assign out_data = mem_reg[rd_ptr_reg];

  always_comb begin
    push = in_valid && ready_reg;
    pop = out_ready && !empty_reg;
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next = AW'(wr_ptr_reg + 1'b1);
    end
    if (pop) begin
      rd_ptr_next = AW'(rd_ptr_reg + 1'b1);
    end
    if (push && !pop) begin
      count_next = CW'(count_reg + 1'b1);
    end else if (pop && !push) begin
      count_next = CW'(count_reg - 1'b1);
    end
    ready_next = (count_next != CW'(DEPTH));
    empty_next = (count_next == '0);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b1;
      empty_reg <= 1'b1;
    end else if (clk_en) begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
      empty_reg <= empty_next;
    end
  end

endmodule : lwc_fifo

// >>> hw/lwc_host.sv
`timescale 1ns/1ps
`include "lwc_cfg.svh"

module lwc_host import lwc_pkg::*; #(
  parameter int SETTLE_CYC = (`LWC_MODE_SETTLE_NS * `LWC_CLK_MHZ + 999) / 1000,
  parameter int INIT_CYC = (`LWC_NORMAL_INIT_NS * `LWC_CLK_MHZ + 999) / 1000,
  parameter int BIT_CYC = (`LWC_BIT_NS * `LWC_CLK_MHZ) / 1000,
  parameter int DW = `LWC_FIFO_WIDTH,
  parameter int DEPTH = `LWC_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire lwc_cmd_t cmd,
  input wire logic [DW-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic rxd,
  output logic en,
  output logic txd,
  output logic rx_level,
  output logic wake_seen,
  output lwc_stat_t status
);
  localparam int TW = 16;
  localparam logic [TW-1:0] SETTLE_T = TW'(SETTLE_CYC);
  localparam logic [TW-1:0] WAKE_T = TW'(SETTLE_CYC + INIT_CYC);
  localparam logic [TW-1:0] BIT_T = TW'(BIT_CYC);
  localparam int FB = `LWC_FRAME_BITS;

  //////////////////////////////////////////////////////////////////////
  // data buffer in front of the serializer
  logic [DW-1:0] fifo_data;
  logic fifo_valid, fifo_pop;

  lwc_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  //////////////////////////////////////////////////////////////////////
  // mode tracking and select pin
  lwc_mode_t mode_reg, mode_next;
  logic [TW-1:0] timer_reg, timer_next;
  logic en_reg, en_next, pend_reg, pend_next, wake_reg, wake_next;
  logic rx_reg, rx_next;
  logic busy_reg;

  always_comb begin
    mode_next = mode_reg;
    timer_next = (timer_reg != '0) ? TW'(timer_reg - 1'b1) : timer_reg;
    en_next = en_reg;
    pend_next = pend_reg || cmd.go_sleep;
    wake_next = 1'b0;
    rx_next = 1'b1;
    case (mode_reg)
      LWC_PWRUP: begin
        // select held low so the part comes up in standby
        if (timer_reg == '0) begin
          mode_next = LWC_STANDBY;
        end
      end
      LWC_STANDBY: begin
        // sleep only reachable through normal, so a pending sleep wakes first
        if (cmd.go_normal || pend_next) begin
          en_next = 1'b1;
          timer_next = WAKE_T;
          mode_next = LWC_TO_NORMAL;
        end
      end
      LWC_TO_NORMAL: begin
        if (timer_reg == '0) begin
          mode_next = LWC_NORMAL;
        end
      end
      LWC_NORMAL: begin
        rx_next = rxd;
        if (pend_reg && !busy_reg && !fifo_valid) begin
          en_next = 1'b0;
          timer_next = SETTLE_T;
          pend_next = 1'b0;
          mode_next = LWC_TO_SLEEP;
        end
      end
      LWC_TO_SLEEP: begin
        // receive output is not trusted while the part switches
        if (timer_reg == '0) begin
          mode_next = LWC_SLEEP;
        end
      end
      default: begin
        pend_next = 1'b0;
        if (cmd.go_normal) begin
          en_next = 1'b1;
          timer_next = WAKE_T;
          mode_next = LWC_TO_NORMAL;
        end else if (!rxd) begin
          // bus wake or undervoltage both read as a low receive line
          wake_next = 1'b1;
          mode_next = LWC_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= LWC_PWRUP;
      timer_reg <= SETTLE_T;
      en_reg <= `LWC_EN_RST;
      pend_reg <= 1'b0;
      wake_reg <= 1'b0;
      rx_reg <= 1'b1;
    end else if (clk_en) begin
      mode_reg <= mode_next;
      timer_reg <= timer_next;
      en_reg <= en_next;
      pend_reg <= pend_next;
      wake_reg <= wake_next;
      rx_reg <= rx_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // byte serializer: start bit, 8 data bits lsb first, stop bit
  logic busy_next, txd_reg, txd_next;
  logic [FB-1:0] shift_reg, shift_next;
  logic [3:0] bit_reg, bit_next;
  logic [TW-1:0] baud_reg, baud_next;

  always_comb begin
    busy_next = busy_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    baud_next = baud_reg;
    fifo_pop = 1'b0;
    // stalling here while not normal lets the fifo fill up
    if (!busy_reg) begin
      // keeps draining while sleep is pending, else sleep would wait forever
      if (mode_reg == LWC_NORMAL && fifo_valid) begin
        fifo_pop = 1'b1;
        busy_next = 1'b1;
        shift_next = {1'b1, fifo_data, 1'b0};
        bit_next = '0;
        baud_next = BIT_T;
      end
    end else if (baud_reg > TW'(1)) begin
      baud_next = TW'(baud_reg - 1'b1);
    end else if (bit_reg == 4'(FB - 1)) begin
      busy_next = 1'b0;
      shift_next = '1;
    end else begin
      shift_next = {1'b1, shift_reg[FB-1:1]};
      bit_next = 4'(bit_reg + 1'b1);
      baud_next = BIT_T;
    end
    txd_next = busy_next ? shift_next[0] : 1'b1;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
      shift_reg <= '1;
      bit_reg <= '0;
      baud_reg <= '0;
      txd_reg <= `LWC_TXD_RST;
    end else if (clk_en) begin
      busy_reg <= busy_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      baud_reg <= baud_next;
      txd_reg <= txd_next;
    end
  end

  assign en = en_reg;
  assign txd = txd_reg;
  assign rx_level = rx_reg;
  assign wake_seen = wake_reg;
  assign status = '{mode: mode_reg, sleep_pending: pend_reg, tx_busy: busy_reg};

  //////////////////////////////////////////////////////////////////////
  // checks; helper counters measure how long the select level has stood
  logic [TW-1:0] hi_cnt, lo_cnt;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
    end else if (clk_en) begin
      hi_cnt <= en_reg ? ((hi_cnt == '1) ? hi_cnt : TW'(hi_cnt + 1'b1)) : '0;
      lo_cnt <= !en_reg ? ((lo_cnt == '1) ? lo_cnt : TW'(lo_cnt + 1'b1)) : '0;
    end
  end

  property p_pwrup_low;
    @(posedge clock) disable iff (!rst_b)
    (mode_reg == LWC_PWRUP) |-> !en_reg;
  endproperty
  a_pwrup_low: assert property (p_pwrup_low) else $error("select high at power-up");

  property p_wake_hold;
    @(posedge clock) disable iff (!rst_b)
    (mode_reg == LWC_TO_NORMAL && mode_next == LWC_NORMAL && clk_en)
      |-> en_reg && (hi_cnt >= WAKE_T);
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("normal entered too early");

  property p_sleep_hold;
    @(posedge clock) disable iff (!rst_b)
    (mode_reg == LWC_TO_SLEEP && mode_next == LWC_SLEEP && clk_en)
      |-> !en_reg && (lo_cnt >= SETTLE_T);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep entered too early");

  property p_local_wake;
    @(posedge clock) disable iff (!rst_b)
    (mode_reg == LWC_SLEEP && cmd.go_normal && clk_en)
      |=> en_reg && mode_reg == LWC_TO_NORMAL;
  endproperty
  a_local_wake: assert property (p_local_wake) else $error("local wake not raised");

  property p_blank_rx;
    @(posedge clock) disable iff (!rst_b)
    (mode_reg == LWC_TO_SLEEP) |=> !wake_reg;
  endproperty
  a_blank_rx: assert property (p_blank_rx) else $error("wake taken while settling");

  property p_low_rx;
    @(posedge clock) disable iff (!rst_b)
    (mode_reg == LWC_SLEEP && !rxd && !cmd.go_normal && clk_en)
      |=> wake_reg && mode_reg == LWC_STANDBY;
  endproperty
  a_low_rx: assert property (p_low_rx) else $error("low receive not reported");

  property p_tx_quiet;
    @(posedge clock) disable iff (!rst_b)
    (mode_reg != LWC_NORMAL && !busy_reg) |-> txd_reg;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("transmit active outside normal");

  property p_rx_follow;
    @(posedge clock) disable iff (!rst_b)
    (mode_reg == LWC_NORMAL && mode_next == LWC_NORMAL && clk_en) |=> rx_reg == $past(rxd);
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("receive level not mirrored");

endmodule : lwc_host

// >>> hw/lwc_pkg.sv
package lwc_pkg;

  typedef enum logic [5:0] {
    LWC_PWRUP = 6'h01,
    LWC_STANDBY = 6'h02,
    LWC_TO_NORMAL = 6'h04,
    LWC_NORMAL = 6'h08,
    LWC_TO_SLEEP = 6'h10,
    LWC_SLEEP = 6'h20
  } lwc_mode_t;

  typedef struct packed {
    logic go_normal;
    logic go_sleep;
  } lwc_cmd_t;

  typedef struct packed {
    lwc_mode_t mode;
    logic sleep_pending;
    logic tx_busy;
  } lwc_stat_t;

endpackage : lwc_pkg

// >>> test/lwc_host_tb.sv
`timescale 1ns/1ps
module lwc_host_tb import lwc_pkg::*;;
  localparam int S = 8;
  localparam int I = 4;
  localparam int B = 4;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic tx_valid = 1'b0;
  logic remote_dom = 1'b0;
  logic clk_en = 1'b0;
  logic [7:0] tx_data = 8'h00;
  lwc_cmd_t cmd = '0;
  logic tx_ready, rxd, en, txd, rx_level, wake_seen;
  logic [1:0] xmode;
  lwc_stat_t status;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int wakes = 0;
  logic [7:0] q [4] = '{8'h5a, 8'h01, 8'h80, 8'hff};

  lwc_host #(.SETTLE_CYC(S), .INIT_CYC(I), .BIT_CYC(B)) u_lwc_host (
    .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .cmd(cmd), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rxd(rxd), .en(en), .txd(txd),
    .rx_level(rx_level), .wake_seen(wake_seen), .status(status)
  );
  lwc_xcvr_model #(.SETTLE_CYC(S), .INIT_CYC(I), .FILT_CYC(6)) u_lwc_xcvr_model (
    .clock(clock), .rst_b(rst_b), .en(en), .txd(txd), .remote_dom(remote_dom),
    .rxd(rxd), .bus(), .mode(xmode)
  );
  ////////////////////////////////////////
  initial forever #2.5 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    if (wake_seen === 1'b1) wakes++;
    if (cycles == 3000) begin
      failures++;
      $display("Error at %0t: timeout", $time);
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic give_verdict();
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic wait_for(input lwc_mode_t m);
    int k;
    k = 0;
    while (status.mode !== m && k < 100) begin
      tick(1);
      k++;
    end
    check(status.mode === m, "mode not reached");
  endtask : wait_for

  task automatic pulse(input logic nrm);
    cmd.go_normal = nrm;
    cmd.go_sleep = ~nrm;
    tick(1);
    cmd = '0;
  endtask : pulse

  // valid stays up on return; each push drives it high again and the caller drops it
  task automatic push(input logic [7:0] d);
    int k;
    k = 0;
    tx_data = d;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && k < 50) begin
      tick(1);
      k++;
    end
    tick(1);
  endtask : push

  task automatic go_normal();
    pulse(1'b1);
    check(en === 1'b1 && status.mode === LWC_TO_NORMAL, "en rise");
    tick(S + I);
    check(status.mode === LWC_TO_NORMAL, "normal too early");
    tick(1);
    check(status.mode === LWC_NORMAL && xmode === 2'd2, "not normal");
  endtask : go_normal

  task automatic go_sleep();
    int k;
    k = 0;
    pulse(1'b0);
    check(status.sleep_pending === 1'b1, "sleep not pending");
    while (en !== 1'b0 && k < 400) begin
      tick(1);
      k++;
    end
    check(status.mode === LWC_TO_SLEEP, "no sleep start");
    check(status.sleep_pending === 1'b0, "pending kept");
    tick(S);
    check(status.mode === LWC_TO_SLEEP, "sleep too early");
    tick(1);
    check(status.mode === LWC_SLEEP && xmode === 2'd0, "not asleep");
  endtask : go_sleep

  // samples one cycle into each bit; gap is cycles from the stop bit sample to next start
  task automatic frame(input logic [7:0] d, input int gap);
    int k;
    logic [9:0] f;
    k = 0;
    while (txd !== 1'b0 && k < 100) begin
      tick(1);
      k++;
    end
    check(status.tx_busy === 1'b1, "busy low in frame");
    if (gap >= 0) check(k == gap, "frame gap");
    tick(1);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd;
      if (i < 9) tick(B);
    end
    check(f === {1'b1, d, 1'b0}, "frame bits");
  endtask : frame
  ////////////////////////////////////////
  task automatic s_fill();
    wait_for(LWC_STANDBY);
    check(xmode === 2'd1 && en === 1'b0, "standby");
    for (int i = 0; i < 4; i++) push(q[i]);
    check(tx_ready === 1'b0, "not full");
    tx_data = 8'h33;
    tick(3);
    check(tx_ready === 1'b0 && txd === 1'b1, "sent in standby");
    tx_valid = 1'b0;
  endtask : s_fill

  task automatic s_normal();
    go_normal();
    // one idle cycle follows each stop bit before the next start
    for (int i = 0; i < 4; i++) frame(q[i], i == 0 ? -1 : 4);
    check(tx_ready === 1'b1, "not drained");
    remote_dom = 1'b1;
    tick(2);
    check(rx_level === 1'b0, "rx dominant");
    remote_dom = 1'b0;
    tick(2);
    check(rx_level === 1'b1, "rx recessive");
  endtask : s_normal

  task automatic s_wake();
    int w;
    go_sleep();
    w = wakes;
    remote_dom = 1'b1;
    tick(3);
    remote_dom = 1'b0;
    tick(10);
    check(wakes == w && status.mode === LWC_SLEEP, "short pulse woke");
    remote_dom = 1'b1;
    tick(8);
    remote_dom = 1'b0;
    tick(4);
    check(wakes == w + 1 && status.mode === LWC_STANDBY && en === 1'b0, "no wake");
    go_normal();
    tick(2);
    check(rx_level === 1'b1, "wake level held");
  endtask : s_wake

  // sleep entered on a stuck bus must not wake when it clears
  task automatic s_lock();
    int w;
    remote_dom = 1'b1;
    go_sleep();
    w = wakes;
    tick(10);
    remote_dom = 1'b0;
    tick(6);
    check(wakes == w && status.mode === LWC_SLEEP, "lockout woke");
    remote_dom = 1'b1;
    tick(8);
    remote_dom = 1'b0;
    wait_for(LWC_STANDBY);
    pulse(1'b0);
    wait_for(LWC_SLEEP);
    check(en === 1'b0 && xmode === 2'd0, "resleep");
    go_normal();
  endtask : s_lock
  ////////////////////////////////////////
  initial begin
    tick(3);
    check(en === 1'b0 && txd === 1'b1 && rx_level === 1'b1, "reset pins");
    check(status.mode === LWC_PWRUP && wake_seen === 1'b0, "reset state");
    rst_b = 1'b1;
    tick(20);
    check(status.mode === LWC_PWRUP && en === 1'b0, "frozen power-up moved");
    clk_en = 1'b1;
    s_fill();
    s_normal();
    s_wake();
    s_lock();
    give_verdict();
  end
endmodule : lwc_host_tb

// >>> test/lwc_xcvr_model.sv
`timescale 1ns/1ps
module lwc_xcvr_model #(
  parameter int SETTLE_CYC = 8,
  parameter int INIT_CYC = 4,
  parameter int FILT_CYC = 6
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic en,
  input wire logic txd,
  input wire logic remote_dom,
  output logic rxd,
  output logic bus,
  output logic [1:0] mode
);
  // mode: 0 sleep, 1 standby, 2 normal
  int hi_cnt;
  int lo_cnt;
  int dom_cnt;
  logic lock_reg;
  logic bus_reg;
  ////////////////////////////////////////
  // wired-and bus; only normal mode drives it
  assign bus = ~remote_dom & (mode != 2'd2 | txd);
  // open drain with pull-up, so sleep reads high
  assign rxd = (mode == 2'd2) ? bus : (mode == 2'd0);
  ////////////////////////////////////////
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode <= en ? 2'd2 : 2'd1;
      hi_cnt <= 0;
      lo_cnt <= 0;
      dom_cnt <= 0;
      lock_reg <= 1'b0;
      bus_reg <= 1'b1;
    end else begin
      bus_reg <= bus;
      hi_cnt <= en ? hi_cnt + 1 : 0;
      lo_cnt <= en ? 0 : lo_cnt + 1;
      dom_cnt <= (bus | lock_reg) ? 0 : dom_cnt + 1;
      if (bus) lock_reg <= 1'b0;
      if (mode == 2'd2 && lo_cnt >= SETTLE_CYC) begin
        mode <= 2'd0;
        lock_reg <= ~bus;
      end else if (mode != 2'd2 && hi_cnt >= SETTLE_CYC + INIT_CYC) begin
        mode <= 2'd2;
      end else if (mode == 2'd0 && bus && !bus_reg && dom_cnt >= FILT_CYC) begin
        mode <= 2'd1;
      end
    end
  end
endmodule : lwc_xcvr_model
